/* File: include/timer_module_pkg.sv */
// Constants, types and mode decoding shared by the timer module files.
// What this block does
// - Each block has two 16-bit counters, separate or joined as 32-bit timer or RTC.
// - Four independent timer blocks, each configured on its own.
// - All block conversion triggers are ORed into one converter trigger.
// - Pins are general-purpose I/O after reset until alternate function is selected.
// - The 8-bit prescaler extends 16-bit one-shot and periodic modes only.
// - RTC mode counts seconds derived from an external 32.768 kHz reference.
// - With stalling enabled, one-shot and periodic modes stop counting during debug halt.
// - Each 16-bit counter supports edge count and edge time capture.
// - Each 16-bit counter has simple PWM with selectable output inversion.
// - Only the first block has pins: even pin first counter, odd pin second.
// - Reset clears control, sets counters and loads to 0xffff, prescalers to 0x00.
// - Configuration 0 is 32-bit timer, 1 is 32-bit RTC, 0x4 is split 16-bit.
// - At zero a counter reloads next cycle, flags timeout; one-shot then disables.
// - First RTC selection loads 1; on match roll to zero, keep counting, flag.
package timer_module_pkg;

   localparam int          NUM_BLOCKS    = 4;
   localparam int          NUM_COUNTERS  = 8;
   localparam logic [2:0]  CFG_32_TIMER  = 3'h0;
   localparam logic [2:0]  CFG_32_RTC    = 3'h1;
   localparam logic [2:0]  CFG_16_SPLIT  = 3'h4;
   localparam logic [1:0]  MODE_ONESHOT  = 2'h1;
   localparam logic [1:0]  MODE_PERIODIC = 2'h2;
   localparam logic [1:0]  MODE_CAPTURE  = 2'h3;
   localparam logic [15:0] COUNT_RESET   = 16'hffff;
   localparam logic [15:0] LOAD_RESET    = 16'hffff;
   localparam logic [7:0]  PRESCALE_RESET = 8'h00;
   localparam logic [31:0] RTC_START     = 32'h0000_0001;
   localparam int          RTC_REF_HZ    = 32768;
   localparam int          RTC_TICK_HZ   = 1;
   localparam int          RTC_DIV       = RTC_REF_HZ / RTC_TICK_HZ;

   typedef enum logic [8:0] {
      F_IDLE   = 9'h001,
      F_OS16   = 9'h002,
      F_PER16  = 9'h004,
      F_CNT16  = 9'h008,
      F_TIME16 = 9'h010,
      F_PWM16  = 9'h020,
      F_OS32   = 9'h040,
      F_PER32  = 9'h080,
      F_RTC    = 9'h100
   } func_t;

   // Decodes the block configuration and counter mode into one function.
   function automatic func_t decode_func(input logic [2:0] cfg, input logic [1:0] mode,
                                         input logic cap_time, input logic pwm, input logic is_odd);
      decode_func = F_IDLE;
      case (cfg)
         CFG_32_RTC: begin
            if (!is_odd) decode_func = F_RTC;
         end
         CFG_32_TIMER: begin
            if (!is_odd && mode == MODE_ONESHOT) decode_func = F_OS32;
            if (!is_odd && mode == MODE_PERIODIC) decode_func = F_PER32;
         end
         CFG_16_SPLIT: begin
            case (mode)
               MODE_ONESHOT: decode_func = F_OS16;
               MODE_PERIODIC: decode_func = F_PER16;
               MODE_CAPTURE: begin
                  if (pwm) decode_func = F_PWM16;
                  else if (cap_time) decode_func = F_TIME16;
                  else decode_func = F_CNT16;
               end
               default: decode_func = F_IDLE;
            endcase
         end
         default: decode_func = F_IDLE;
      endcase
   endfunction : decode_func

endpackage : timer_module_pkg

/* File: hw/timer_pin_unit.sv */
// Shared capture pin: general-purpose I/O or timer alternate function.
`timescale 1ns/1ns
module timer_pin_unit (
   // Clock and reset.
   input  wire logic clk_in,
   input  wire logic nrst_in,
   // Pin side.
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe_n_out,
   // Function select and GPIO side.
   input  wire logic alt_select_in,
   input  wire logic gpio_data_in,
   input  wire logic gpio_drive_in,
   output logic      gpio_read_out,
   // Timer side.
   input  wire logic pwm_active_in,
   input  wire logic pwm_level_in,
   output logic      edge_out
);

   logic pin_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_q         <= 1'b0;
         edge_out      <= 1'b0;
         gpio_read_out <= 1'b0;
      end else begin
         pin_q         <= pin_in;
         gpio_read_out <= pin_in;
         edge_out      <= pin_in & ~pin_q & alt_select_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_out      <= 1'b0;
         pin_oe_n_out <= 1'b1;
      end else if (alt_select_in) begin
         pin_out      <= pwm_level_in;
         pin_oe_n_out <= ~pwm_active_in;
      end else begin
         pin_out      <= gpio_data_in;
         pin_oe_n_out <= ~gpio_drive_in;
      end
   end

endmodule : timer_pin_unit

/* File: hw/timer_module.sv */
// Four general-purpose timer blocks with eight 16-bit counters and shared trigger.
`timescale 1ns/1ns
module timer_module
   import timer_module_pkg::*;
#(
   parameter int RTC_DIVIDE = RTC_DIV
) (
   // Clock and reset.
   input  wire logic                   clk_in,
   input  wire logic                   nrst_in,
   // Block configuration and counter modes.
   input  wire logic [3:0][2:0]        cfg_in,
   input  wire logic [7:0][1:0]        mode_in,
   input  wire logic [7:0]             cap_time_in,
   input  wire logic [7:0]             pwm_mode_in,
   input  wire logic [7:0]             pwm_invert_in,
   // Counter control.
   input  wire logic [7:0]             enable_set_in,
   input  wire logic [7:0]             enable_clr_in,
   input  wire logic [7:0]             stall_en_in,
   input  wire logic [7:0]             trig_en_in,
   input  wire logic                   debug_halt_in,
   input  wire logic [7:0]             load_wr_in,
   input  wire logic [7:0][15:0]       load_data_in,
   input  wire logic [7:0][7:0]        prescale_in,
   input  wire logic [7:0][15:0]       match_in,
   // Flag clears.
   input  wire logic [7:0]             timeout_clr_in,
   input  wire logic [7:0]             capture_clr_in,
   input  wire logic [3:0]             rtc_clr_in,
   // Capture pins of the first block.
   input  wire logic                   capture_pin_even_in,
   output logic                        capture_pin_even_out,
   output logic                        capture_pin_even_oe_n_out,
   input  wire logic                   capture_pin_odd_in,
   output logic                        capture_pin_odd_out,
   output logic                        capture_pin_odd_oe_n_out,
   input  wire logic [1:0]             alt_function_select_in,
   input  wire logic [1:0]             gpio_data_in,
   input  wire logic [1:0]             gpio_drive_in,
   output logic [1:0]                  gpio_read_out,
   // Status.
   output logic [7:0]                  enable_out,
   output logic [7:0][15:0]            count_out,
   output logic [7:0][15:0]            capture_out,
   output logic [7:0]                  timeout_flag_out,
   output logic [7:0]                  capture_flag_out,
   output logic [3:0]                  rtc_flag_out,
   output logic                        trigger_out
);

   logic [7:0][15:0] cnt;
   logic [7:0][15:0] next_cnt;
   logic [7:0][7:0]  pre;
   logic [7:0][7:0]  next_pre;
   logic [7:0][15:0] load;
   logic [7:0][15:0] next_load;
   logic [7:0][15:0] capt;
   logic [7:0][15:0] next_capt;
   logic [7:0]       en;
   logic [7:0]       hw_clr;
   logic [7:0]       tmo_ev;
   logic [7:0]       cap_ev;
   logic [3:0]       rtc_ev;
   logic [3:0]       rtc_used;
   logic [3:0]       next_rtc_used;
   logic [7:0]       tmo_flag;
   logic [7:0]       cap_flag;
   logic [3:0]       rtc_flag;
   logic [7:0]       pwm_act;
   logic [7:0]       pwm_lvl;
   logic [7:0]       edge_ev;
   logic             edge_even;
   logic             edge_odd;
   logic [15:0]      rtc_div;
   logic             rtc_tick;
   logic             trig;

   assign edge_ev = {6'h00, edge_odd, edge_even};

   // Only the first block's counters are wired to pins.
   timer_pin_unit u_pin_even (
      .clk_in        (clk_in),
      .nrst_in       (nrst_in),
      .pin_in        (capture_pin_even_in),
      .pin_out       (capture_pin_even_out),
      .pin_oe_n_out  (capture_pin_even_oe_n_out),
      .alt_select_in (alt_function_select_in[0]),
      .gpio_data_in  (gpio_data_in[0]),
      .gpio_drive_in (gpio_drive_in[0]),
      .gpio_read_out (gpio_read_out[0]),
      .pwm_active_in (pwm_act[0]),
      .pwm_level_in  (pwm_lvl[0]),
      .edge_out      (edge_even)
   );

   timer_pin_unit u_pin_odd (
      .clk_in        (clk_in),
      .nrst_in       (nrst_in),
      .pin_in        (capture_pin_odd_in),
      .pin_out       (capture_pin_odd_out),
      .pin_oe_n_out  (capture_pin_odd_oe_n_out),
      .alt_select_in (alt_function_select_in[1]),
      .gpio_data_in  (gpio_data_in[1]),
      .gpio_drive_in (gpio_drive_in[1]),
      .gpio_read_out (gpio_read_out[1]),
      .pwm_active_in (pwm_act[1]),
      .pwm_level_in  (pwm_lvl[1]),
      .edge_out      (edge_odd)
   );

   // Divides the reference edges on the even pin down to a one-second tick.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rtc_div  <= 16'h0000;
         rtc_tick <= 1'b0;
      end else if (edge_ev[0] && rtc_div == 16'(RTC_DIVIDE - 1)) begin
         rtc_div  <= 16'h0000;
         rtc_tick <= 1'b1;
      end else begin
         rtc_div  <= edge_ev[0] ? rtc_div + 16'h0001 : rtc_div;
         rtc_tick <= 1'b0;
      end
   end

   // Computes the next state of every counter from its block function.
   always_comb begin
      func_t       f;
      int          hi;
      logic [31:0] c32;
      logic        run;
      f             = F_IDLE;
      hi            = 0;
      c32           = 32'h0000_0000;
      run           = 1'b0;
      next_cnt      = cnt;
      next_pre      = pre;
      next_load     = load;
      next_capt     = capt;
      next_rtc_used = rtc_used;
      hw_clr        = 8'h00;
      tmo_ev        = 8'h00;
      cap_ev        = 8'h00;
      rtc_ev        = 4'h0;
      pwm_act       = 8'h00;
      for (int i = 0; i < NUM_COUNTERS; i++) begin
         f   = decode_func(cfg_in[i >> 1], mode_in[i], cap_time_in[i], pwm_mode_in[i], i[0]);
         hi  = i | 1;
         c32 = {cnt[hi], cnt[i]};
         run = en[i] & ~(debug_halt_in & stall_en_in[i]);
         case (f)
            F_OS32, F_PER32: begin
               if (run) begin
                  if (c32 == 32'h0000_0000) begin
                     {next_cnt[hi], next_cnt[i]} = {load[hi], load[i]};
                     tmo_ev[i] = 1'b1;
                     hw_clr[i] = (f == F_OS32);
                  end else begin
                     {next_cnt[hi], next_cnt[i]} = c32 - 32'h0000_0001;
                  end
               end
            end
            F_RTC: begin
               if (!rtc_used[i >> 1]) begin
                  {next_cnt[hi], next_cnt[i]} = RTC_START;
                  next_rtc_used[i >> 1] = 1'b1;
               end else if (en[i] && rtc_tick) begin
                  if (c32 == {match_in[hi], match_in[i]}) begin
                     {next_cnt[hi], next_cnt[i]} = 32'h0000_0000;
                     rtc_ev[i >> 1] = 1'b1;
                  end else begin
                     {next_cnt[hi], next_cnt[i]} = c32 + 32'h0000_0001;
                  end
               end
            end
            F_OS16, F_PER16: begin
               if (run) begin
                  if (pre[i] != 8'h00) begin
                     next_pre[i] = pre[i] - 8'h01;
                  end else if (cnt[i] == 16'h0000) begin
                     next_cnt[i] = load[i];
                     next_pre[i] = prescale_in[i];
                     tmo_ev[i]   = 1'b1;
                     hw_clr[i]   = (f == F_OS16);
                  end else begin
                     next_cnt[i] = cnt[i] - 16'h0001;
                     next_pre[i] = prescale_in[i];
                  end
               end
            end
            F_CNT16: begin
               if (en[i] && edge_ev[i]) begin
                  if (cnt[i] == match_in[i]) begin
                     next_cnt[i] = load[i];
                     cap_ev[i]   = 1'b1;
                  end else begin
                     next_cnt[i] = cnt[i] - 16'h0001;
                  end
               end
            end
            F_TIME16: begin
               if (en[i]) begin
                  next_cnt[i] = (cnt[i] == 16'h0000) ? load[i] : cnt[i] - 16'h0001;
                  if (edge_ev[i]) begin
                     next_capt[i] = cnt[i];
                     cap_ev[i]    = 1'b1;
                  end
               end
            end
            F_PWM16: begin
               pwm_act[i] = en[i];
               if (en[i]) begin
                  next_cnt[i] = (cnt[i] == 16'h0000) ? load[i] : cnt[i] - 16'h0001;
               end
            end
            default: begin
            end
         endcase
         if (load_wr_in[i]) begin
            next_load[i] = load_data_in[i];
            next_cnt[i]  = load_data_in[i];
            next_pre[i]  = prescale_in[i];
            if (cfg_in[i >> 1] == CFG_32_TIMER && !i[0]) begin
               next_load[hi] = load_data_in[hi];
               next_cnt[hi]  = load_data_in[hi];
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt      <= {NUM_COUNTERS{COUNT_RESET}};
         load     <= {NUM_COUNTERS{LOAD_RESET}};
         pre      <= {NUM_COUNTERS{PRESCALE_RESET}};
         capt     <= {NUM_COUNTERS{16'h0000}};
         rtc_used <= 4'h0;
      end else begin
         cnt      <= next_cnt;
         load     <= next_load;
         pre      <= next_pre;
         capt     <= next_capt;
         rtc_used <= next_rtc_used;
      end
   end

   // Enables: a one-shot expiry clears its enable unless software sets it again.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         en <= 8'h00;
      end else begin
         en <= ((en & ~hw_clr) | enable_set_in) & ~enable_clr_in;
      end
   end

   // Sticky flags; an event in the clearing cycle wins.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tmo_flag <= 8'h00;
         cap_flag <= 8'h00;
         rtc_flag <= 4'h0;
      end else begin
         tmo_flag <= (tmo_flag & ~timeout_clr_in) | tmo_ev;
         cap_flag <= (cap_flag & ~capture_clr_in) | cap_ev;
         rtc_flag <= (rtc_flag & ~rtc_clr_in) | rtc_ev;
      end
   end

   // PWM level and combined conversion trigger.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pwm_lvl <= 8'h00;
         trig    <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_COUNTERS; i++) begin
            pwm_lvl[i] <= (cnt[i] > match_in[i]) ^ pwm_invert_in[i];
         end
         trig <= |(tmo_ev & trig_en_in);
      end
   end

   assign enable_out       = en;
   assign count_out        = cnt;
   assign capture_out      = capt;
   assign timeout_flag_out = tmo_flag;
   assign capture_flag_out = cap_flag;
   assign rtc_flag_out     = rtc_flag;
   assign trigger_out      = trig;

endmodule : timer_module

/* File: bench/pin_source.sv */
// Event source and load model for the two shared capture pins.
`timescale 1ns/1ns
module pin_source (
   // Clock.
   input  wire logic       clk_in,
   // Device side of the pins.
   input  wire logic [1:0] dut_data_in,
   input  wire logic [1:0] dut_oe_n_in,
   // Resolved pin levels.
   output logic [1:0]      pin_out
);
   logic [1:0] drive = 2'h0;

   // The device owns the wire only while its output enable is low.
   assign pin_out = (dut_data_in & ~dut_oe_n_in) | (drive & dut_oe_n_in);

   // Sends rising edges, each one cycle high and one cycle low.
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge clk_in);
         #1;
         drive[idx] = 1'b1;
         @(posedge clk_in);
         #1;
         drive[idx] = 1'b0;
      end
   endtask : pulse
endmodule : pin_source

/* File: bench/timer_module_sva.sv */
// Concurrent checks on the timer module ports.
`timescale 1ns/1ns
module timer_module_sva
   import timer_module_pkg::*;
(
   // Clock and reset.
   input wire logic             clk_in,
   input wire logic             nrst_in,
   // Control.
   input wire logic [3:0][2:0]  cfg_in,
   input wire logic [7:0][1:0]  mode_in,
   input wire logic [7:0]       enable_set_in,
   input wire logic [7:0]       enable_clr_in,
   input wire logic [7:0]       stall_en_in,
   input wire logic [7:0]       trig_en_in,
   input wire logic             debug_halt_in,
   input wire logic [7:0]       load_wr_in,
   input wire logic [7:0][7:0]  prescale_in,
   input wire logic [1:0]       alt_function_select_in,
   input wire logic [1:0]       gpio_data_in,
   input wire logic [1:0]       gpio_drive_in,
   // Outputs.
   input wire logic             capture_pin_even_oe_n_out,
   input wire logic             capture_pin_odd_out,
   input wire logic             capture_pin_odd_oe_n_out,
   input wire logic [7:0]       enable_out,
   input wire logic [7:0][15:0] count_out,
   input wire logic [7:0]       timeout_flag_out,
   input wire logic [7:0]       capture_flag_out,
   input wire logic [3:0]       rtc_flag_out,
   input wire logic             trigger_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   a_reset_state: assert property (
      $rose(nrst_in) |-> count_out == {8{COUNT_RESET}} && enable_out == 8'h00 && !trigger_out)
      else $error("Timer state after reset is wrong.");
   a_trig_pulse: assert property (trigger_out |=> !trigger_out)
      else $error("Trigger lasted more than one cycle.");
   a_trig_cause: assert property (
      trigger_out |-> |($past(trig_en_in) & timeout_flag_out))
      else $error("Trigger without an enabled timeout.");
   a_oneshot_stop: assert property (
      $rose(timeout_flag_out[1]) && cfg_in[0] == CFG_16_SPLIT && mode_in[1] == MODE_ONESHOT
      && !$past(enable_set_in[1]) |-> !enable_out[1])
      else $error("One-shot counter stayed enabled.");
   a_zero_reload: assert property (
      cfg_in[0] == CFG_16_SPLIT && mode_in[0] == MODE_PERIODIC && enable_out[0] && count_out[0] == 16'h0
      && prescale_in[0] == 8'h00 && !load_wr_in[0] && !enable_clr_in[0] && !stall_en_in[0]
      |=> timeout_flag_out[0] && trigger_out == $past(trig_en_in[0]))
      else $error("Zero count gave no timeout.");
   a_stall_hold: assert property (
      stall_en_in[2] && debug_halt_in && cfg_in[1] == CFG_16_SPLIT && mode_in[2] == MODE_PERIODIC
      && !load_wr_in[2] |=> $stable(count_out[2]))
      else $error("Counter moved during debug halt.");
   a_even_idle: assert property (
      !alt_function_select_in[0] && !gpio_drive_in[0] |=> capture_pin_even_oe_n_out)
      else $error("Even pin driven without a function.");
   a_gpio_drive: assert property (
      !alt_function_select_in[1] && gpio_drive_in[1]
      |=> !capture_pin_odd_oe_n_out && capture_pin_odd_out == $past(gpio_data_in[1]))
      else $error("Odd pin does not follow its general output.");
   a_no_pins: assert property (capture_flag_out[7:2] == 6'h00)
      else $error("Capture event on a counter without a pin.");
   a_rtc_roll: assert property (
      $rose(rtc_flag_out[2]) |-> {count_out[5], count_out[4]} == 32'h0)
      else $error("Clock count did not roll to zero on match.");
endmodule : timer_module_sva

bind timer_module timer_module_sva u_sva (.clk_in, .nrst_in, .cfg_in, .mode_in, .enable_set_in, .enable_clr_in,
   .stall_en_in, .trig_en_in, .debug_halt_in, .load_wr_in, .prescale_in, .alt_function_select_in, .gpio_data_in,
   .gpio_drive_in, .capture_pin_even_oe_n_out, .capture_pin_odd_out, .capture_pin_odd_oe_n_out, .enable_out,
   .count_out, .timeout_flag_out, .capture_flag_out, .rtc_flag_out, .trigger_out);

/* File: bench/tb.sv */
// Self-checking testbench for the timer module.
`timescale 1ns/1ns
module tb
   import timer_module_pkg::*;
;
   logic             clk_in, nrst_in, debug_halt_in, trigger_out;
   logic [3:0][2:0]  cfg_in;
   logic [7:0][1:0]  mode_in;
   logic [7:0]       cap_time_in, pwm_mode_in, pwm_invert_in, enable_set_in, enable_clr_in;
   logic [7:0]       stall_en_in, trig_en_in, load_wr_in, timeout_clr_in, capture_clr_in;
   logic [7:0]       enable_out, timeout_flag_out, capture_flag_out;
   logic [3:0]       rtc_clr_in, rtc_flag_out;
   logic [7:0][15:0] load_data_in, match_in, count_out, capture_out;
   logic [7:0][7:0]  prescale_in;
   logic [1:0]       alt_function_select_in, gpio_data_in, gpio_drive_in, gpio_read_out, pin;
   logic             capture_pin_even_out, capture_pin_even_oe_n_out, capture_pin_odd_out, capture_pin_odd_oe_n_out;
   int               err_count = 0, compares = 0, cyc = 0, n, hi;

   timer_module #(.RTC_DIVIDE(4)) u_dut (.clk_in, .nrst_in, .cfg_in, .mode_in, .cap_time_in, .pwm_mode_in,
      .pwm_invert_in, .enable_set_in, .enable_clr_in, .stall_en_in, .trig_en_in, .debug_halt_in, .load_wr_in,
      .load_data_in, .prescale_in, .match_in, .timeout_clr_in, .capture_clr_in, .rtc_clr_in,
      .capture_pin_even_in(pin[0]), .capture_pin_even_out, .capture_pin_even_oe_n_out,
      .capture_pin_odd_in(pin[1]), .capture_pin_odd_out, .capture_pin_odd_oe_n_out, .alt_function_select_in,
      .gpio_data_in, .gpio_drive_in, .gpio_read_out, .enable_out, .count_out, .capture_out, .timeout_flag_out,
      .capture_flag_out, .rtc_flag_out, .trigger_out);
   pin_source u_src (.clk_in, .dut_data_in({capture_pin_odd_out, capture_pin_even_out}),
      .dut_oe_n_in({capture_pin_odd_oe_n_out, capture_pin_even_oe_n_out}), .pin_out(pin));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic end_of_test();
      if (err_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic step(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask : step

   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %0h, expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic load(input int i, input logic [15:0] d);
      load_data_in[i] = d;
      load_wr_in = 8'h01 << i;
      step(1);
      load_wr_in = 8'h00;
   endtask : load

   task automatic en(input logic [7:0] m);
      enable_set_in = m;
      step(1);
      enable_set_in = 8'h00;
   endtask : en

   task automatic dis(input logic [7:0] m);
      enable_clr_in = m;
      step(1);
      enable_clr_in = 8'h00;
   endtask : dis

   task automatic wait_trig(output int cnt);
      cnt = 0;
      do begin
         step(1);
         cnt++;
      end while (trigger_out !== 1'b1 && cnt < 50);
   endtask : wait_trig

   initial begin
      {mode_in, cap_time_in, pwm_mode_in, pwm_invert_in, enable_set_in, enable_clr_in, stall_en_in} = '0;
      {trig_en_in, debug_halt_in, load_wr_in, load_data_in, prescale_in, match_in, timeout_clr_in} = '0;
      {capture_clr_in, rtc_clr_in, alt_function_select_in, gpio_data_in, gpio_drive_in} = '0;
      cfg_in = {6'h00, CFG_16_SPLIT, CFG_16_SPLIT};
      nrst_in = 1'b0;
      step(3);
      nrst_in = 1'b1;
      step(1);
      chk(count_out, {8{16'hffff}});
      chk({enable_out, timeout_flag_out, trigger_out, capture_pin_even_oe_n_out}, 18'h1);
      mode_in[0] = MODE_PERIODIC;
      trig_en_in = 8'h01;
      load(0, 16'h2);
      en(8'h01);
      step(1);
      chk(count_out[0], 16'h1);
      step(1);
      chk({count_out[0], trigger_out}, 17'h0);
      step(1);
      chk({count_out[0], timeout_flag_out[0], trigger_out}, 18'h00b);
      timeout_clr_in = 8'h01;
      step(1);
      chk({count_out[0], trigger_out}, 17'h2);
      timeout_clr_in = 8'h00;
      step(1);
      chk(timeout_flag_out[0], 1'b0);
      dis(8'h01);
      trig_en_in = 8'h00;
      mode_in[1] = MODE_ONESHOT;
      load(1, 16'h1);
      en(8'h02);
      step(2);
      chk({enable_out[1], timeout_flag_out[1], count_out[1]}, 18'h10001);
      step(2);
      chk(count_out[1], 16'h1);
      mode_in[2] = MODE_PERIODIC;
      stall_en_in = 8'h04;
      debug_halt_in = 1'b1;
      load(2, 16'h10);
      en(8'h04);
      step(5);
      chk(count_out[2], 16'h10);
      debug_halt_in = 1'b0;
      step(3);
      chk(count_out[2], 16'h0d);
      dis(8'h04);
      mode_in[3] = MODE_PERIODIC;
      trig_en_in = 8'h08;
      load(3, 16'h1);
      en(8'h08);
      for (int p = 0; p < 3; p++) begin
         prescale_in[3] = p[7:0];
         repeat (3) wait_trig(n);
         chk(n, 2 * (p + 1));
      end
      dis(8'h08);
      trig_en_in = 8'h00;
      mode_in[2:1] = {MODE_CAPTURE, MODE_CAPTURE};
      match_in[2:1] = {16'h5, 16'h1};
      load(2, 16'h5);
      step(1);
      load(1, 16'h3);
      en(8'h06);
      u_src.pulse(1, 1);
      step(3);
      chk(count_out[1], 16'h3);
      alt_function_select_in = 2'h2;
      u_src.pulse(1, 2);
      step(3);
      chk({count_out[1], capture_flag_out[1]}, 17'h2);
      u_src.pulse(1, 1);
      step(3);
      chk({count_out[1], capture_flag_out}, 24'h0302);
      cap_time_in[1] = 1'b1;
      capture_clr_in = 8'h02;
      step(1);
      capture_clr_in = 8'h00;
      load(1, 16'h40);
      chk(capture_flag_out[1], 1'b0);
      u_src.pulse(1, 1);
      step(3);
      chk({capture_out[1], capture_flag_out[1]}, 17'h0007d);
      dis(8'h06);
      mode_in[0] = MODE_CAPTURE;
      pwm_mode_in = 8'h01;
      alt_function_select_in = 2'h3;
      load(0, 16'h3);
      en(8'h01);
      for (int v = 0; v < 2; v++) begin
         pwm_invert_in[0] = v[0];
         step(4);
         hi = 0;
         for (int k = 0; k < 8; k++) begin
            step(1);
            hi += (pin[0] === 1'b1);
         end
         chk({hi, capture_pin_even_oe_n_out}, {v ? 32'd2 : 32'd6, 1'b0});
      end
      dis(8'h01);
      pwm_mode_in = 8'h00;
      mode_in[0] = 2'h0;
      alt_function_select_in = 2'h1;
      gpio_data_in = 2'h2;
      gpio_drive_in = 2'h2;
      step(4);
      chk({pin[1], gpio_read_out, capture_pin_odd_oe_n_out}, 4'hc);
      gpio_drive_in = 2'h0;
      mode_in[6] = MODE_ONESHOT;
      load_data_in[7] = 16'h1;
      load(6, 16'h0);
      en(8'h40);
      step(1);
      chk({count_out[7], count_out[6]}, 32'hffff);
      mode_in[4] = MODE_PERIODIC;
      load(4, 16'h1);
      en(8'h10);
      step(4);
      chk({enable_out[4], timeout_flag_out[4], count_out[5], count_out[4]}, 34'h3_0000_0001);
      nrst_in = 1'b0;
      step(2);
      nrst_in = 1'b1;
      match_in[4] = 16'h2;
      cfg_in[2] = CFG_32_RTC;
      step(2);
      chk({count_out[5], count_out[4]}, 32'h1);
      en(8'h10);
      u_src.pulse(0, 4);
      step(4);
      chk({count_out[5], count_out[4]}, 32'h2);
      u_src.pulse(0, 4);
      step(4);
      chk({count_out[5], count_out[4], rtc_flag_out}, 36'h4);
      end_of_test();
   end
endmodule : tb
